//--- hw/rst_wdt_pkg.sv
package rst_wdt_pkg;
    localparam int CLK_HZ           = 10_000_000;
    localparam int WDT_OSC_HZ       = 128_000;
    localparam int WDT_DIV          = CLK_HZ / WDT_OSC_HZ;
    localparam int WDT_BASE_TICKS   = 2048;
    localparam int WDT_PRESC_MAX    = 9;
    localparam int CHG_WINDOW       = 4;
    localparam int STARTUP_MIN_CYC  = 14;
    localparam int STARTUP_BASE_US  = 4100;
    localparam int STARTUP_BASE_CYC = STARTUP_BASE_US * (CLK_HZ / 1_000_000);
    localparam int STARTUP_LONG_MUL = 16;
    localparam int XTAL_START_CYC   = 16384;
    // Register byte offsets
    localparam logic [3:0] REG_WDT_CTRL  = 4'h0;
    localparam logic [3:0] REG_RST_FLAGS = 4'h4;
    localparam logic [3:0] REG_PWR       = 4'h8;
    localparam logic [3:0] REG_STATUS    = 4'hC;
    // Watchdog control fields
    localparam int WDC_IRQ_FLAG = 7;
    localparam int WDC_IRQ_EN   = 6;
    localparam int WDC_PRESC3   = 5;
    localparam int WDC_CHG_EN   = 4;
    localparam int WDC_RST_EN   = 3;
    localparam int WDC_PRESC_HI = 2;
    // Reset flags, power and status fields
    localparam int RF_WDT       = 3;
    localparam int RF_BOR       = 2;
    localparam int RF_EXT       = 1;
    localparam int RF_POR       = 0;
    localparam int PWR_ADC_PRR  = 0;
    localparam int ST_BANDGAP   = 0;
    localparam int ST_WDT_RUN   = 1;
    localparam int ST_ADC_EN    = 2;
    localparam logic [3:0] RST_FLAGS_INIT = 4'h1;
    localparam logic [2:0] BROWNOUT_OFF   = 3'h7;

    typedef struct packed {
        logic por;
        logic ext;
        logic wdt;
        logic bor;
    } rst_src_t;

    // Fuse bits: 1 means programmed
    typedef struct packed {
        logic [1:0] startup_time_fuse;
        logic [3:0] clock_source_fuse;
        logic       reset_pin_disable_fuse;
        logic [2:0] brownout_level_fuse;
        logic       watchdog_always_on_fuse;
    } fuse_t;
endpackage : rst_wdt_pkg

//--- hw/reset_and_watchdog_control.sv
`timescale 1ns/1ns
module reset_and_watchdog_control #(
    parameter int STARTUP_BASE_CYCLES = rst_wdt_pkg::STARTUP_BASE_CYC,
    parameter int XTAL_START_CYCLES   = rst_wdt_pkg::XTAL_START_CYC,
    parameter int WDT_BASE            = rst_wdt_pkg::WDT_BASE_TICKS,
    parameter int DLY_W               = 21,
    parameter int WDT_CNT_W           = 20
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [3:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Reset sources and fuses
    input  wire logic              por_active_i,
    input  wire logic              ext_reset_n_i,
    input  wire logic              brownout_below_i,
    input  wire rst_wdt_pkg::fuse_t fuses_i,
    // Core and analog side
    input  wire logic              wdr_i,
    input  wire logic              wdt_irq_ack_i,
    input  wire logic              adc_enable_i,
    input  wire logic              comparator_bandgap_select_i,
    output logic                   internal_reset_o,
    output logic                   reset_vector_o,
    output logic                   wdt_irq_o,
    output logic                   bandgap_on_o,
    output logic                   adc_shutdown_o,
    output logic                   comparator_mux_ok_o
);
    import rst_wdt_pkg::*;

    localparam logic [6:0] WDT_DIV_LAST = 7'(WDT_DIV - 1);
    localparam logic [2:0] CHG_LOAD     = 3'(CHG_WINDOW);

    rst_src_t               src;
    logic                   any_src;
    logic                   brownout_en;
    logic [DLY_W-1:0]       dly_cnt;
    logic [DLY_W-1:0]       dly_load;
    logic [DLY_W-1:0]       dly_base;
    logic                   in_rst_q;
    logic                   wdt_rst_pulse;
    logic [6:0]             div_cnt;
    logic                   wdt_tick;
    logic [WDT_CNT_W-1:0]   wdt_cnt;
    logic                   irq_flag;
    logic                   irq_en_r;
    logic                   rst_en_r;
    logic [3:0]             presc;
    logic [2:0]             chg_cnt;
    logic                   chg_en;
    logic                   eff_rst_en;
    logic                   eff_irq_en;
    logic                   wdt_run;
    logic                   timeout;
    logic                   to_irq;
    logic                   to_rst;
    logic [3:0]             rflags;
    logic                   adc_prr;
    logic                   req;
    logic                   wr;
    logic [7:0]             wdata;
    logic                   wr_wdc;
    logic                   wr_rf;
    logic                   wr_pwr;
    logic                   arm;
    logic [7:0]             rdata;

    // Time-out in oscillator ticks for a prescale code
    function automatic logic [WDT_CNT_W-1:0] wdt_limit(
        input logic [3:0] code
    );
        logic [3:0] c;
        c = (code > 4'(WDT_PRESC_MAX)) ? 4'(WDT_PRESC_MAX) : code;
        wdt_limit = WDT_CNT_W'((WDT_BASE << c) - 1);
    endfunction : wdt_limit

    // Reset source combination, asynchronous to the clock
    assign brownout_en = fuses_i.brownout_level_fuse != BROWNOUT_OFF;
    assign src.por = por_active_i;
    assign src.ext = !ext_reset_n_i
                     && !fuses_i.reset_pin_disable_fuse;
    assign src.wdt = wdt_rst_pulse;
    assign src.bor = brownout_en && brownout_below_i;
    assign any_src = |src;

    // Start-up delay chosen by fuses
    always_comb begin
        unique case (fuses_i.startup_time_fuse)
            2'h0: dly_base = DLY_W'(STARTUP_MIN_CYC);
            2'h1: dly_base = DLY_W'(STARTUP_BASE_CYCLES);
            2'h2: dly_base = DLY_W'(STARTUP_BASE_CYCLES * STARTUP_LONG_MUL);
            2'h3: dly_base = DLY_W'(STARTUP_BASE_CYCLES * STARTUP_LONG_MUL);
        endcase
        dly_load = dly_base;
        if (fuses_i.clock_source_fuse[3]) begin
            dly_load = dly_base + DLY_W'(XTAL_START_CYCLES);
        end
    end

    // Delay counter reloads while any source is active
    always_ff @(posedge clk_i) begin
        if (rst_i || any_src) begin
            dly_cnt <= dly_load;
        end else if (dly_cnt != '0) begin
            dly_cnt <= dly_cnt - 1'b1;
        end
    end

    // Immediate path so ports reset without a clock
    assign internal_reset_o = rst_i || any_src
                              || (dly_cnt != '0);

    // Restart pulse toward the core fetch unit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_rst_q       <= 1'b1;
            reset_vector_o <= 1'b0;
        end else begin
            in_rst_q       <= internal_reset_o;
            reset_vector_o <= in_rst_q && !internal_reset_o;
        end
    end

    // Watchdog oscillator enable from the system clock
    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            div_cnt  <= '0;
            wdt_tick <= 1'b0;
        end else if (div_cnt == WDT_DIV_LAST) begin
            div_cnt  <= '0;
            wdt_tick <= 1'b1;
        end else begin
            div_cnt  <= div_cnt + 1'b1;
            wdt_tick <= 1'b0;
        end
    end

    // Effective mode bits
    assign eff_rst_en = rst_en_r || rflags[RF_WDT]
                        || fuses_i.watchdog_always_on_fuse;
    assign eff_irq_en = irq_en_r
                        && !fuses_i.watchdog_always_on_fuse;
    assign wdt_run    = eff_rst_en || eff_irq_en;
    assign timeout    = wdt_run && wdt_tick
                        && (wdt_cnt >= wdt_limit(presc));
    // Combined mode: second expiry with flag pending resets
    assign to_irq = timeout && eff_irq_en
                    && !(eff_rst_en && irq_flag);
    assign to_rst = timeout && eff_rst_en
                    && !(eff_irq_en && !irq_flag);

    always_ff @(posedge clk_i) begin
        if (internal_reset_o || wdr_i || !wdt_run) begin
            wdt_cnt <= '0;
        end else if (timeout) begin
            wdt_cnt <= '0;
        end else if (wdt_tick) begin
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // One clock wide; its own reset clears the counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_rst_pulse <= 1'b0;
        end else begin
            wdt_rst_pulse <= to_rst;
        end
    end

    // Bus decode; writes land at the edge that sees ack
    assign req    = cyc_i && stb_i;
    assign wr     = req && we_i && ack_o && sel_i[0];
    assign wdata  = dat_i[7:0];
    assign wr_wdc = wr && (adr_i == REG_WDT_CTRL);
    assign wr_rf  = wr && (adr_i == REG_RST_FLAGS);
    assign wr_pwr = wr && (adr_i == REG_PWR);
    assign arm    = wr_wdc && wdata[WDC_CHG_EN]
                    && wdata[WDC_RST_EN];
    assign chg_en = chg_cnt != '0;

    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            chg_cnt <= '0;
        end else if (arm) begin
            chg_cnt <= CHG_LOAD;
        end else if (chg_en) begin
            chg_cnt <= chg_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            rst_en_r <= 1'b0;
        end else if (wr_wdc) begin
            if (wdata[WDC_RST_EN]) begin
                rst_en_r <= 1'b1;
            end else if (chg_en && !wdata[WDC_CHG_EN]) begin
                rst_en_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            presc <= '0;
        end else if (wr_wdc && chg_en && !wdata[WDC_CHG_EN]) begin
            presc <= {wdata[WDC_PRESC3],
                      wdata[WDC_PRESC_HI:0]};
        end
    end

    // Vector entry in combined mode drops to reset mode
    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            irq_en_r <= 1'b0;
        end else if (wdt_irq_ack_i && eff_rst_en) begin
            irq_en_r <= 1'b0;
        end else if (wr_wdc) begin
            irq_en_r <= wdata[WDC_IRQ_EN];
        end
    end

    // Set wins over either clear
    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            irq_flag <= 1'b0;
        end else if (to_irq) begin
            irq_flag <= 1'b1;
        end else if (wdt_irq_ack_i
                     || (wr_wdc && wdata[WDC_IRQ_FLAG])) begin
            irq_flag <= 1'b0;
        end
    end

    assign wdt_irq_o = irq_flag && eff_irq_en;

    // Reset cause flags survive all but power-on and rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i || src.por) begin
            rflags <= RST_FLAGS_INIT;
        end else begin
            rflags[RF_POR] <= rflags[RF_POR]
                              && !(wr_rf && !wdata[RF_POR]);
            rflags[RF_EXT] <= src.ext || (rflags[RF_EXT]
                              && !(wr_rf && !wdata[RF_EXT]));
            rflags[RF_BOR] <= src.bor || (rflags[RF_BOR]
                              && !(wr_rf && !wdata[RF_BOR]));
            rflags[RF_WDT] <= src.wdt || (rflags[RF_WDT]
                              && !(wr_rf && !wdata[RF_WDT]));
        end
    end

    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            adc_prr <= 1'b0;
        end else if (wr_pwr) begin
            adc_prr <= wdata[PWR_ADC_PRR];
        end
    end

    assign adc_shutdown_o      = adc_prr;
    assign comparator_mux_ok_o = !adc_prr;
    assign bandgap_on_o        = brownout_en || comparator_bandgap_select_i
                                 || adc_enable_i;

    // Read multiplexer
    always_comb begin
        rdata = '0;
        unique case (adr_i)
            REG_WDT_CTRL: begin
                rdata[WDC_IRQ_FLAG]   = irq_flag;
                rdata[WDC_IRQ_EN]     = eff_irq_en;
                rdata[WDC_PRESC3]     = presc[3];
                rdata[WDC_CHG_EN]     = chg_en;
                rdata[WDC_RST_EN]     = eff_rst_en;
                rdata[WDC_PRESC_HI:0] = presc[2:0];
            end
            REG_RST_FLAGS: begin
                rdata[3:0] = rflags;
            end
            REG_PWR: begin
                rdata[PWR_ADC_PRR] = adc_prr;
            end
            REG_STATUS: begin
                rdata[ST_BANDGAP] = bandgap_on_o;
                rdata[ST_WDT_RUN] = wdt_run;
                rdata[ST_ADC_EN]  = adc_enable_i;
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (internal_reset_o) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req && !ack_o;
            if (req && !ack_o) begin
                dat_o <= {24'h00_0000, rdata};
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_src_reset;
        any_src |-> internal_reset_o;
    endproperty
    a_src_reset: assert property (p_src_reset)
        else $error("reset source active without internal reset");

    property p_stretch;
        $fell(any_src) |-> internal_reset_o
                           && dly_cnt == $past(dly_load);
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("start-up delay not loaded at source release");

    property p_por_now;
        $rose(por_active_i) |-> internal_reset_o;
    endproperty
    a_por_now: assert property (p_por_now)
        else $error("power-on reset not immediate");

    property p_brownout;
        brownout_en && brownout_below_i
        |-> internal_reset_o ##1 rflags[RF_BOR];
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brown-out reset or flag missing");

    property p_ext_off;
        fuses_i.reset_pin_disable_fuse && !por_active_i
        && !(brownout_en && brownout_below_i) && !wdt_rst_pulse
        && dly_cnt == '0 |-> !internal_reset_o;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("disabled reset pin still resets");

    property p_wdt_pulse;
        wdt_rst_pulse |=> !wdt_rst_pulse && internal_reset_o
                          && dly_cnt == $past(dly_load);
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse)
        else $error("watchdog reset pulse not one clock");

    property p_chg_window;
        $rose(chg_en) |-> chg_en[*4];
    endproperty
    a_chg_window: assert property (p_chg_window)
        else $error("change window shorter than four clocks");

    property p_chg_end;
        chg_cnt == 3'h1 && !arm |=> !chg_en;
    endproperty
    a_chg_end: assert property (p_chg_end)
        else $error("change window not closed");

    property p_presc_lock;
        !chg_en && !internal_reset_o |=> presc == $past(presc);
    endproperty
    a_presc_lock: assert property (p_presc_lock)
        else $error("prescale changed outside window");

    property p_always_on;
        fuses_i.watchdog_always_on_fuse |-> eff_rst_en && !wdt_irq_o;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("always-on fuse not forcing reset mode");

    property p_watchdog_reset_flag;
        rflags[RF_WDT] |-> eff_rst_en;
    endproperty
    a_watchdog_reset_flag: assert property (p_watchdog_reset_flag)
        else $error("reset enable clear while watchdog flag set");

    property p_reset_mode;
        timeout && eff_rst_en && !eff_irq_en |=> wdt_rst_pulse;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("reset mode expiry without reset");

    property p_combined;
        timeout && eff_rst_en && eff_irq_en && !irq_flag
        |=> irq_flag && !wdt_rst_pulse;
    endproperty
    a_combined: assert property (p_combined)
        else $error("combined mode first expiry wrong");

    property p_irq_flag;
        timeout && eff_irq_en && !eff_rst_en |=> irq_flag;
    endproperty
    a_irq_flag: assert property (p_irq_flag)
        else $error("interrupt flag not set on expiry");

    property p_wdr;
        wdr_i |=> wdt_cnt == '0;
    endproperty
    a_wdr: assert property (p_wdr)
        else $error("watchdog restart did not clear counter");

    property p_vector;
        $fell(internal_reset_o) |=> reset_vector_o ##1 !reset_vector_o;
    endproperty
    a_vector: assert property (p_vector)
        else $error("no restart pulse after reset release");

    property p_adc_off;
        adc_prr |-> adc_shutdown_o && !comparator_mux_ok_o;
    endproperty
    a_adc_off: assert property (p_adc_off)
        else $error("ADC shutdown state inconsistent");

    c_wdt_reset: cover property (wdt_rst_pulse);
    c_wdt_irq:   cover property (to_irq ##[1:1000] wdt_irq_ack_i);
    c_unlock:    cover property (arm ##[1:4] (wr_wdc && chg_en));
    c_ext_reset: cover property ($rose(src.ext));
endmodule : reset_and_watchdog_control

//--- tb/pin_supply_model.sv
`timescale 1ns/1ns
module pin_supply_model #(
    parameter int MIN_LOW = 4
) (
    // Clock
    input  wire logic clk_i,
    // Requests from the bench
    input  wire logic por_req_i,
    input  wire logic ext_req_i,
    input  wire logic bor_req_i,
    // Supply monitors and reset pin
    output logic      por_active_o,
    output logic      ext_reset_n_o,
    output logic      brownout_below_o
);
    int low_cnt = 0;

    always_ff @(posedge clk_i) begin
        if (!ext_reset_n_o) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt <= 0;
        end
    end
    // A short request still holds the pin low for the minimum width
    assign ext_reset_n_o = !(ext_req_i || (low_cnt > 0 && low_cnt < MIN_LOW));
    assign por_active_o = por_req_i;
    assign brownout_below_o = bor_req_i;
endmodule : pin_supply_model

//--- tb/reset_and_watchdog_control_test.sv
`timescale 1ns/1ns
module reset_and_watchdog_control_test;
    import rst_wdt_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, wdr_i, irq_ack;
    logic [3:0]  adr_i, sel_i;
    logic [31:0] dat_i, dat_o, rd;
    fuse_t       fuses;
    logic        adc_en, cmp_sel, por_req, ext_req, bor_req;
    logic        por_act, ext_n, bor_below, int_rst, rst_vec, irq, bg, shut, mux_ok;
    int          fails, tests_run;
    // {por,ext,bor,pin_off} {bod_off,expect_reset,0,0} {flags}
    localparam logic [11:0] SRC_ROWS [5] = '{12'h841, 12'h442, 12'h244,
                                              12'h500, 12'h280};
    // {op: 0 read, 1 write, 2 always-on fuse} {data}
    localparam logic [11:0] WD_ROWS [17] = '{12'h105, 12'h000, 12'h118,
        12'h018, 12'h008, 12'h105, 12'h008, 12'h118, 12'h10D, 12'h00D,
        12'h118, 12'h100, 12'h000, 12'h140, 12'h040, 12'h201, 12'h008};

    reset_and_watchdog_control #(.STARTUP_BASE_CYCLES(20),
        .XTAL_START_CYCLES(8), .WDT_BASE(4)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .por_active_i(por_act),
        .ext_reset_n_i(ext_n), .brownout_below_i(bor_below),
        .fuses_i(fuses), .wdr_i(wdr_i), .wdt_irq_ack_i(irq_ack),
        .adc_enable_i(adc_en), .comparator_bandgap_select_i(cmp_sel),
        .internal_reset_o(int_rst), .reset_vector_o(rst_vec),
        .wdt_irq_o(irq), .bandgap_on_o(bg), .adc_shutdown_o(shut),
        .comparator_mux_ok_o(mux_ok));

    pin_supply_model #(.MIN_LOW(4)) partner (
        .clk_i(clk_i), .por_req_i(por_req), .ext_req_i(ext_req),
        .bor_req_i(bor_req), .por_active_o(por_act),
        .ext_reset_n_o(ext_n), .brownout_below_o(bor_below));

    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1;
        stb_i <= 1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        sel_i <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            print_verdict();
        end
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask : wb

    task automatic wait_release(input int exp);
        int n;
        logic v1, v2;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (int_rst !== 1'b0 && n < 200);
        chk("release_cycles", exp, n);
        if (n >= 200) begin
            print_verdict();
        end
        v1 = rst_vec;
        @(posedge clk_i);
        #1;
        v2 = rst_vec;
        chk("reset_vector", 1, v1 + v2);
        @(posedge clk_i);
    endtask : wait_release

    task automatic wait_for(input bit pick_irq, input string name);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while ((pick_irq ? irq : int_rst) !== 1'b1 && n < 1000);
        chk(name, 1, pick_irq ? irq : int_rst);
        if (n >= 1000) begin
            print_verdict();
        end
    endtask : wait_for

    initial begin
        fails = 0;
        tests_run = 0;
        {cyc_i, stb_i, we_i, wdr_i, irq_ack, adc_en, cmp_sel} = '0;
        {por_req, ext_req, bor_req, adr_i, sel_i, dat_i} = '0;
        fuses = '0;
        fuses.brownout_level_fuse = 3'h4;
        rst_i = 1;
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        wait_release(14);
        wb(0, REG_RST_FLAGS, 8'h00, rd);
        chk("flags_init", 32'h0000_0001, rd);
        foreach (SRC_ROWS[i]) begin
            fuses.reset_pin_disable_fuse <= SRC_ROWS[i][8];
            fuses.brownout_level_fuse <= SRC_ROWS[i][7] ? 3'h7 : 3'h4;
            wb(1, REG_RST_FLAGS, 8'h00, rd);
            {por_req, ext_req, bor_req} <= SRC_ROWS[i][11:9];
            #1;
            chk("reset_now", SRC_ROWS[i][6], int_rst);
            repeat (6) @(posedge clk_i);
            {por_req, ext_req, bor_req} <= 3'h0;
            if (SRC_ROWS[i][6]) begin
                wait_release(14);
            end
            wb(0, REG_RST_FLAGS, 8'h00, rd);
            chk("flags", {28'h0, SRC_ROWS[i][3:0]}, rd);
        end
        for (int i = 0; i < 8; i++) begin
            adc_en <= i[0];
            cmp_sel <= i[1];
            fuses.brownout_level_fuse <= i[2] ? 3'h4 : 3'h7;
            #1;
            chk("bandgap_on", i != 0, bg);
            @(posedge clk_i);
        end
        adc_en <= 0;
        wb(1, REG_PWR, 8'h01, rd);
        chk("adc_shutdown", 1, shut);
        chk("comparator_mux_ok", 0, mux_ok);
        wb(0, 4'h2, 8'h00, rd);
        chk("unmapped", 0, rd);
        wdr_i <= 1;
        @(posedge clk_i);
        wdr_i <= 0;
        foreach (WD_ROWS[i]) begin
            if (WD_ROWS[i][11:8] == 4'h2) begin
                fuses.watchdog_always_on_fuse <= WD_ROWS[i][0];
                @(posedge clk_i);
            end else if (WD_ROWS[i][8]) begin
                wb(1, REG_WDT_CTRL, WD_ROWS[i][7:0], rd);
            end else begin
                wb(0, REG_WDT_CTRL, 8'h00, rd);
                chk("wdt_ctrl", {24'h0, WD_ROWS[i][7:0]}, rd);
            end
        end
        // Forced reset mode expires, pulses reset and sets its flag
        wait_for(0, "wdt_reset");
        wait_release(15);
        wb(0, REG_RST_FLAGS, 8'h00, rd);
        chk("wdt_flag", 32'h0000_0008, rd);
        fuses.watchdog_always_on_fuse <= 0;
        wb(1, REG_RST_FLAGS, 8'h00, rd);
        wb(1, REG_WDT_CTRL, 8'h40, rd);
        wait_for(1, "wdt_irq");
        @(posedge clk_i);
        irq_ack <= 1;
        @(posedge clk_i);
        irq_ack <= 0;
        #1;
        chk("wdt_irq_cleared", 0, irq);
        @(posedge clk_i);
        print_verdict();
    end
endmodule : reset_and_watchdog_control_test
